// *** src/ocd_pkg.sv ***
// constants and types of the on-screen display character write decoder
// ---------------------------------------------------------------
// Overview of operation
// - rims are always one minimum dot wide, whatever the row's character size.
// - background none shows dots only; minimum pads one dot; overall fills screen.
// - outside colour blanking, secondary-flagged characters vanish from colour and primary channels, with no background there.
// - secondary channel gets background only in cells of secondary-flagged characters.
// - colour-blanking mode uses only colour background bits; secondary channel stays silent.
// - colour-blanking mode drives primary channel with OR of red, green and blue.
// - nine-bit test command; test mode refused while factory check pin is grounded.
// - character first byte: 1,1,inverse,red,green,blue,flash,secondary; second byte pattern.
// - video RAM writes are dropped while the LC oscillator is stopped.
// - after a full command each further byte writes a character, column advancing.
// - column 23 wraps to column 0 of next row; row 11 wraps to row 0.
// - red-green-blue bits give eight colours, zeros black, ones white.
// - per-character colour reaches only the colour channel; others are single colour.
// - flash bit blinks the character, gated by the screen-wide blink enable.
// - inverse bit reverses the character; screen-wide reversal is separate.
// - secondary bit routes character to secondary channel only; ignored in colour blanking.
// - top pattern address ends continuous input; the one below is display-off data.
// - continuous input ends by select high or end code; select may stay low.
// - blank shows background; display-off shows nothing, neither image nor rim nor background, in every mode.
// - on the 128-pattern variant the top pattern address bit is ignored.
// - bit order is fixed by option, MSB first or LSB first, same fields.
// - rims never cross a cell's top or bottom edge; sideways they may.
// ---------------------------------------------------------------
package ocd_pkg;
   localparam int          BYTE_W          = 8;
   localparam logic [4:0]  LAST_COL        = 5'h17;
   localparam logic [3:0]  LAST_ROW        = 4'hB;
   localparam logic [1:0]  CHAR_PREFIX     = 2'h3;
   localparam logic [1:0]  TWO_BYTE_PREFIX = 2'h2;
   localparam logic [6:0]  TEST_PREFIX     = 7'h58;
   localparam logic [7:0]  END_CODE        = 8'hFF;
   localparam logic [7:0]  OFF_CODE        = 8'hFE;
   localparam logic [1:0]  BG_NONE         = 2'h0;
   localparam logic [1:0]  BG_MIN          = 2'h1;
   // attribute byte field positions
   localparam int          AT_INV          = 5;
   localparam int          AT_RED          = 4;
   localparam int          AT_BLUE         = 2;
   localparam int          AT_FLASH        = 1;
   localparam int          AT_SEC          = 0;
   // synchroniser lanes
   localparam int          SY_DAT          = 0;
   localparam int          SY_CLK          = 1;
   localparam int          SY_CS           = 2;
   localparam int          SY_CHK          = 3;
   localparam int          SY_OSC          = 4;
   localparam logic [4:0]  SY_RST          = 5'h04;
   // register map, byte addresses
   localparam logic [3:0]  CTRL_OFS        = 4'h0;
   localparam logic [3:0]  STAT_OFS        = 4'h4;
   localparam logic [15:0] CTRL_RST        = 16'h0000;
   localparam int          CF_BG_RGB       = 0;
   localparam int          CF_BG_PRI       = 2;
   localparam int          CF_BG_SEC       = 4;
   localparam int          CF_RIM          = 6;
   localparam int          CF_BLINK        = 9;
   localparam int          CF_REV          = 10;
   localparam int          CF_CBM          = 11;
   localparam int          CF_BGCOL        = 12;
   localparam int          CF_RIMW         = 15;
   localparam int          SF_ROW          = 8;
   localparam int          SF_TEST         = 12;
   localparam int          SF_CONT         = 13;
   localparam int          SF_TFIELD       = 16;
   // link timing
   localparam int          CLK_NS          = 50;
   localparam int          T_CKL_NS        = 400;
   localparam int          CKL_CYC         = T_CKL_NS / CLK_NS;
   typedef enum logic [2:0] {PH_FIRST, PH_CHAR2, PH_CONT, PH_TEST2, PH_SKIP} ocd_phase_t;
endpackage

// *** src/ocd_char_write.sv ***
// serial character write decoder with video RAM write port and dot mixer
`timescale 1ns/1ps
module ocd_char_write
   import ocd_pkg::*;
#(
   parameter int PATTERN_COUNT = 256,
   parameter bit LSB_FIRST     = 1'b0
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // register bus
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // serial link and pins
   input  wire logic        ser_data_in,
   input  wire logic        ser_clk_in,
   input  wire logic        ser_cs_n_in,
   input  wire logic        factory_check_in,
   input  wire logic        osc_running_in,
   // write address load
   input  wire logic        addr_load_in,
   input  wire logic [3:0]  addr_row_in,
   input  wire logic [4:0]  addr_col_in,
   // video ram write port
   output logic             vram_we_out,
   output logic      [3:0]  vram_row_out,
   output logic      [4:0]  vram_col_out,
   output logic      [5:0]  vram_attr_out,
   output logic      [7:0]  vram_pattern_out,
   // test mode
   output logic             test_mode_out,
   output logic      [8:0]  factory_check_field_out,
   // current dot from raster
   input  wire logic [5:0]  cell_attr_in,
   input  wire logic [7:0]  pattern_code_in,
   input  wire logic [8:0]  cell_dots_in,
   input  wire logic        cell_top_in,
   input  wire logic        cell_bot_in,
   input  wire logic        min_bg_area_in,
   input  wire logic        blink_phase_in,
   // video outputs
   output logic      [2:0]  rgb_out,
   output logic             rgb_blank_out,
   output logic             primary_video_channel_out,
   output logic             primary_blank_out,
   output logic             secondary_video_channel_out,
   output logic             secondary_blank_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic        sck_d;
      logic [7:0]  sh;
      logic [2:0]  bits;
      ocd_phase_t  ph;
      logic [5:0]  attr;
      logic [3:0]  row;
      logic [4:0]  col;
      logic        t8;
      logic        test_mode;
      logic [8:0]  test_field;
      logic        we;
      logic [3:0]  wr_row;
      logic [4:0]  wr_col;
      logic [5:0]  wr_attr;
      logic [7:0]  wr_pat;
      logic [15:0] ctrl;
      logic        ack;
      logic [31:0] rdata;
      logic [2:0]  rgb;
      logic        rgb_blk;
      logic        pri;
      logic        pri_blk;
      logic        sec;
      logic        sec_blk;
   } ocd_state_t;

   ocd_state_t r;
   ocd_state_t n;

   if (PATTERN_COUNT != 256 && PATTERN_COUNT != 128) begin
      $error("pattern count must be 128 or 256");
   end
   if (CKL_CYC < 2) begin
      $error("clock too slow to sample the link clock");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic d);
      shift_in = LSB_FIRST ? {d, sh[7:1]} : {sh[6:0], d};
   endfunction

   function automatic logic [7:0] pat_mask(input logic [7:0] p);
      pat_mask = (PATTERN_COUNT == 128) ? {1'b0, p[6:0]} : p;
   endfunction

   function automatic logic rim_of(input logic [8:0] nb, input logic top, input logic bot);
      logic [8:0] m;
      m = nb;
      if (top) m[2:0] = 3'h0;
      if (bot) m[8:6] = 3'h0;
      rim_of = !m[4] && |{m[8:5], m[3:0]};
   endfunction

   function automatic logic bg_on(input logic [1:0] mode, input logic min_area);
      bg_on = (mode == BG_NONE) ? 1'b0 : (mode == BG_MIN) ? min_area : 1'b1;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic       sck_rise;
      logic       byte_done;
      logic [7:0] byte_v;
      logic [7:0] pat;
      logic       cbm;
      logic       sec_cell;
      logic       off_cell;
      logic       dot;
      logic       rim;
      logic       hit;
      sck_rise  = 1'b0;
      byte_done = 1'b0;
      byte_v    = 8'h00;
      pat       = 8'h00;
      cbm       = 1'b0;
      sec_cell  = 1'b0;
      off_cell  = 1'b0;
      dot       = 1'b0;
      rim       = 1'b0;
      hit       = 1'b0;
      n         = r;
      n.s1      = {osc_running_in, factory_check_in, ser_cs_n_in, ser_clk_in, ser_data_in};
      n.s2      = r.s1;
      n.sck_d   = r.s2[SY_CLK];
      n.we      = 1'b0;
      sck_rise  = r.s2[SY_CLK] && !r.sck_d;

      // serial byte assembly
      if (r.s2[SY_CS]) begin
         n.bits = 3'h0;
         n.ph   = PH_FIRST;
      end else if (sck_rise) begin
         n.sh      = shift_in(r.sh, r.s2[SY_DAT]);
         n.bits    = r.bits + 3'h1;
         byte_done = (r.bits == 3'h7);
      end
      byte_v = n.sh;
      pat    = pat_mask(byte_v);

      // command decode
      if (byte_done) begin
         case (r.ph)
            PH_FIRST: begin
               if (byte_v[7:6] == CHAR_PREFIX) begin
                  n.attr = byte_v[5:0];
                  n.ph   = PH_CHAR2;
               end else if (byte_v[7:1] == TEST_PREFIX) begin
                  n.t8 = byte_v[0];
                  n.ph = PH_TEST2;
               end else if (byte_v[7:6] == TWO_BYTE_PREFIX) begin
                  n.ph = PH_SKIP;
               end
            end
            PH_CHAR2, PH_CONT: begin
               if (pat == pat_mask(END_CODE)) begin
                  n.ph = PH_FIRST;
               end else begin
                  n.ph = PH_CONT;
                  if (r.s2[SY_OSC]) begin
                     n.we      = 1'b1;
                     n.wr_row  = r.row;
                     n.wr_col  = r.col;
                     n.wr_attr = r.attr;
                     n.wr_pat  = pat;
                     if (r.col == LAST_COL) begin
                        n.col = 5'h00;
                        n.row = (r.row == LAST_ROW) ? 4'h0 : r.row + 4'h1;
                     end else begin
                        n.col = r.col + 5'h01;
                     end
                  end
               end
            end
            PH_TEST2: begin
               if (r.s2[SY_CHK]) begin
                  n.test_field = {r.t8, byte_v};
                  n.test_mode  = |{r.t8, byte_v};
               end
               n.ph = PH_FIRST;
            end
            default: n.ph = PH_FIRST;
         endcase
      end
      if (addr_load_in && !n.we) begin
         n.row = addr_row_in;
         n.col = addr_col_in;
      end

      // register bus slave
      n.ack = (avs_read_in || avs_write_in) && !r.ack;
      if (n.ack) begin
         if (avs_address_in == CTRL_OFS) begin
            n.rdata = {16'h0000, r.ctrl};
         end else if (avs_address_in == STAT_OFS) begin
            n.rdata = 32'h00000000;
            n.rdata[4:0]                  = r.col;
            n.rdata[SF_ROW +: 4]          = r.row;
            n.rdata[SF_TEST]              = r.test_mode;
            n.rdata[SF_CONT]              = (r.ph == PH_CONT);
            n.rdata[SF_TFIELD +: 9]       = r.test_field;
         end else begin
            n.rdata = 32'h00000000;
         end
      end
      if (avs_write_in && r.ack && avs_address_in == CTRL_OFS) begin
         if (avs_byteenable_in[0]) n.ctrl[7:0] = avs_writedata_in[7:0];
         if (avs_byteenable_in[1]) n.ctrl[15:8] = avs_writedata_in[15:8];
      end

      // dot mixer
      cbm      = r.ctrl[CF_CBM];
      sec_cell = cell_attr_in[AT_SEC] && !cbm;
      off_cell = (pat_mask(pattern_code_in) == pat_mask(OFF_CODE));
      dot      = cell_dots_in[4] ^ cell_attr_in[AT_INV] ^ r.ctrl[CF_REV];
      if (cell_attr_in[AT_FLASH] && r.ctrl[CF_BLINK] && blink_phase_in) dot = 1'b0;
      if (off_cell) dot = 1'b0;
      rim = rim_of(cell_dots_in, cell_top_in, cell_bot_in) && !off_cell;

      // colour channel
      hit = !sec_cell && !off_cell;
      n.rgb = 3'h0;
      n.rgb_blk = 1'b0;
      if (hit && dot) begin
         n.rgb     = cell_attr_in[AT_RED:AT_BLUE];
         n.rgb_blk = 1'b1;
      end else if (hit && rim && r.ctrl[CF_RIM]) begin
         n.rgb     = {3{r.ctrl[CF_RIMW]}};
         n.rgb_blk = 1'b1;
      end else if (hit && bg_on(r.ctrl[CF_BG_RGB +: 2], min_bg_area_in)) begin
         n.rgb     = r.ctrl[CF_BGCOL +: 3];
         n.rgb_blk = 1'b1;
      end

      // primary and secondary channels
      if (cbm) begin
         n.pri     = |n.rgb;
         n.pri_blk = n.rgb_blk;
         n.sec     = 1'b0;
         n.sec_blk = 1'b0;
      end else begin
         n.pri     = hit && dot;
         n.pri_blk = hit && (dot || (rim && r.ctrl[CF_RIM + 1])
                     || bg_on(r.ctrl[CF_BG_PRI +: 2], min_bg_area_in));
         n.sec     = sec_cell && dot && !off_cell;
         n.sec_blk = sec_cell && !off_cell && (dot || (rim && r.ctrl[CF_RIM + 2])
                     || bg_on(r.ctrl[CF_BG_SEC +: 2], min_bg_area_in));
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         r      <= '0;
         r.s1   <= SY_RST;
         r.s2   <= SY_RST;
         r.ctrl <= CTRL_RST;
      end else begin
         r <= n;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign avs_waitrequest_out         = (avs_read_in || avs_write_in) && !r.ack;
   assign avs_readdata_out            = r.rdata;
   assign vram_we_out                 = r.we;
   assign vram_row_out                = r.wr_row;
   assign vram_col_out                = r.wr_col;
   assign vram_attr_out               = r.wr_attr;
   assign vram_pattern_out            = r.wr_pat;
   assign test_mode_out               = r.test_mode;
   assign factory_check_field_out     = r.test_field;
   assign rgb_out                     = r.rgb;
   assign rgb_blank_out               = r.rgb_blk;
   assign primary_video_channel_out   = r.pri;
   assign primary_blank_out           = r.pri_blk;
   assign secondary_video_channel_out = r.sec;
   assign secondary_blank_out         = r.sec_blk;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   osc_write_gate_a: assert property (
      vram_we_out |-> $past(r.s2[SY_OSC]))
      else $error("video ram written while oscillator stopped");

   col_advance_a: assert property (
      vram_we_out && !addr_load_in && vram_col_out != LAST_COL |-> r.col == vram_col_out + 5'h01)
      else $error("column did not advance after a write");

   wrap_row_a: assert property (
      vram_we_out && vram_col_out == LAST_COL && !addr_load_in
      |-> r.col == 5'h00 && r.row == ((vram_row_out == LAST_ROW) ? 4'h0 : vram_row_out + 4'h1))
      else $error("address wrap wrong");

   test_refused_a: assert property (
      $rose(r.test_mode) |-> $past(r.s2[SY_CHK]))
      else $error("test mode entered with factory check grounded");

   select_reset_a: assert property (
      r.s2[SY_CS] |=> r.bits == 3'h0 && r.ph == PH_FIRST && !r.we)
      else $error("select high did not reset the byte counter");

   end_code_a: assert property (
      (r.ph == PH_CONT || r.ph == PH_CHAR2) && n.ph == PH_FIRST && !r.s2[SY_CS] |=> !vram_we_out)
      else $error("end code wrote a character");

   blank_or_a: assert property (
      $past(r.ctrl[CF_CBM]) |-> primary_video_channel_out == |rgb_out && !secondary_blank_out)
      else $error("colour blanking outputs wrong");

   sec_suppress_a: assert property (
      $past(cell_attr_in[AT_SEC] && !r.ctrl[CF_CBM]) |-> !rgb_blank_out && !primary_blank_out)
      else $error("secondary character leaked to colour or primary");

   sec_bg_only_a: assert property (
      $past(!cell_attr_in[AT_SEC] || r.ctrl[CF_CBM]) |-> !secondary_blank_out)
      else $error("secondary background outside secondary cells");

   off_cell_a: assert property (
      $past(pat_mask(pattern_code_in) == pat_mask(OFF_CODE))
      |-> !rgb_blank_out && !primary_blank_out && !secondary_blank_out)
      else $error("display-off cell shows something");

   flash_gate_a: assert property (
      $past(cell_attr_in[AT_FLASH] && r.ctrl[CF_BLINK] && blink_phase_in && !r.ctrl[CF_CBM])
      |-> !primary_video_channel_out)
      else $error("flashing character shown in its off phase");

   sec_silent_a: assert property (
      $past(r.ctrl[CF_CBM]) |-> !secondary_video_channel_out)
      else $error("secondary channel driven in colour blanking");

   cont_attr_a: assert property (
      vram_we_out |-> vram_attr_out == r.attr)
      else $error("continuous write lost the held attribute");

   pattern_mask_a: assert property (
      vram_we_out && PATTERN_COUNT == 128 |-> !vram_pattern_out[7])
      else $error("top pattern bit kept on the small variant");

   test_hold_a: assert property (
      !$past(r.s2[SY_CHK]) |-> $stable(factory_check_field_out))
      else $error("test field changed with factory check grounded");
endmodule

// *** testbench/ocd_host_model.sv ***
// host side model driving the serial character link
`timescale 1ns/1ps
module ocd_host_model
   import ocd_pkg::*;
#(
   parameter bit LSB_FIRST = 1'b0
) (
   // clock
   input  wire logic clk_in,
   // serial link
   output logic      ser_data_out,
   output logic      ser_clk_out,
   output logic      ser_cs_n_out
);
   initial begin
      ser_data_out = 1'b0;
      ser_clk_out  = 1'b0;
      ser_cs_n_out = 1'b1;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // one byte; link clock idles low between frames
   task automatic send_byte(input logic [7:0] b);
      int i;
      if (ser_cs_n_out) begin
         ser_cs_n_out <= 1'b0;
         wait_cyc(CKL_CYC);
      end
      for (i = 0; i < BYTE_W; i++) begin
         ser_data_out <= LSB_FIRST ? b[i] : b[BYTE_W-1-i];
         wait_cyc(CKL_CYC);
         ser_clk_out <= 1'b1;
         wait_cyc(CKL_CYC);
         ser_clk_out <= 1'b0;
      end
      wait_cyc(CKL_CYC);
   endtask
   // select high ends the frame; released data line shows no stale value
   task automatic end_frame();
      ser_cs_n_out <= 1'b1;
      ser_data_out <= ~ser_data_out;
      wait_cyc(CKL_CYC);
   endtask
endmodule

// *** testbench/ocd_char_write_tb.sv ***
// self-checking bench of the character write decoder
`timescale 1ns/1ps
module ocd_char_write_tb;
   import ocd_pkg::*;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [5:0]  attr;
      logic [7:0]  code;
      logic [8:0]  dots;
      logic [3:0]  ctl;
      logic [7:0]  exp;
   } ocd_row_t;
   // ctl bits: top, bottom, minimum area, blink phase
   // exp bits: rgb, primary, secondary, then blanks of rgb, primary, secondary
   ocd_row_t    rows [18] = '{
      '{16'h0000, 6'h10, 8'h41, 9'h010, 4'h0, 8'h96},
      '{16'h0000, 6'h11, 8'h41, 9'h010, 4'h0, 8'h09},
      '{16'h0800, 6'h0D, 8'h41, 9'h010, 4'h0, 8'h76},
      '{16'h0000, 6'h0C, 8'h41, 9'h000, 4'h0, 8'h00},
      '{16'h0003, 6'h0C, 8'h41, 9'h000, 4'h0, 8'h04},
      '{16'h0003, 6'h0C, 8'hFE, 9'h000, 4'h0, 8'h00},
      '{16'h0030, 6'h10, 8'h41, 9'h000, 4'h0, 8'h00},
      '{16'h0030, 6'h11, 8'h41, 9'h000, 4'h0, 8'h01},
      '{16'h0003, 6'h11, 8'h41, 9'h000, 4'h0, 8'h00},
      '{16'h8040, 6'h10, 8'h41, 9'h100, 4'h0, 8'hE4},
      '{16'h8040, 6'h10, 8'h41, 9'h001, 4'h8, 8'h00},
      '{16'h8040, 6'h10, 8'h41, 9'h100, 4'h4, 8'h00},
      '{16'h5001, 6'h0C, 8'h41, 9'h000, 4'h2, 8'hA4},
      '{16'h5001, 6'h0C, 8'h41, 9'h000, 4'h0, 8'h00},
      '{16'h0200, 6'h12, 8'h41, 9'h010, 4'h1, 8'h00},
      '{16'h0200, 6'h12, 8'h41, 9'h010, 4'h0, 8'h96},
      '{16'h0000, 6'h30, 8'h41, 9'h000, 4'h0, 8'h96},
      '{16'h0400, 6'h30, 8'h41, 9'h000, 4'h0, 8'h00}};
   logic [7:0]  seq [7] = '{8'hD2, 8'h41, 8'h42, 8'h43, 8'hFF, 8'hC1, 8'hFE};
   logic        clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [3:0]  avs_address_in, avs_byteenable_in, addr_row_in, vram_row_out;
   logic [31:0] avs_writedata_in, avs_readdata_out, q;
   logic        link_data, link_clk, link_cs_n, factory_check_in, osc_running_in, addr_load_in;
   logic [4:0]  addr_col_in, vram_col_out;
   logic [5:0]  vram_attr_out, cell_attr_in;
   logic [7:0]  vram_pattern_out, pattern_code_in;
   logic        vram_we_out, test_mode_out, cell_top_in, cell_bot_in, min_bg_area_in, blink_phase_in;
   logic [8:0]  factory_check_field_out, cell_dots_in;
   logic [2:0]  rgb_out;
   logic        rgb_blank_out, pri_out, pri_blank_out, sec_out, sec_blank_out;
   logic [22:0] exp_q [$];
   int          n_errors, tests_run;
   ocd_char_write #(.PATTERN_COUNT(256), .LSB_FIRST(1'b0)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .ser_data_in(link_data), .ser_clk_in(link_clk), .ser_cs_n_in(link_cs_n),
      .factory_check_in(factory_check_in), .osc_running_in(osc_running_in), .addr_load_in(addr_load_in),
      .addr_row_in(addr_row_in), .addr_col_in(addr_col_in), .vram_we_out(vram_we_out),
      .vram_row_out(vram_row_out), .vram_col_out(vram_col_out), .vram_attr_out(vram_attr_out),
      .vram_pattern_out(vram_pattern_out), .test_mode_out(test_mode_out),
      .factory_check_field_out(factory_check_field_out), .cell_attr_in(cell_attr_in),
      .pattern_code_in(pattern_code_in), .cell_dots_in(cell_dots_in), .cell_top_in(cell_top_in),
      .cell_bot_in(cell_bot_in), .min_bg_area_in(min_bg_area_in), .blink_phase_in(blink_phase_in),
      .rgb_out(rgb_out), .rgb_blank_out(rgb_blank_out), .primary_video_channel_out(pri_out),
      .primary_blank_out(pri_blank_out), .secondary_video_channel_out(sec_out),
      .secondary_blank_out(sec_blank_out));
   ocd_host_model #(.LSB_FIRST(1'b0)) host (.clk_in(clk_in), .ser_data_out(link_data),
      .ser_clk_out(link_clk), .ser_cs_n_out(link_cs_n));
   task automatic print_verdict();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // avalon cycle, held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int   n;
      logic w;
      avs_address_in   <= a;
      avs_writedata_in <= d;
      avs_read_in      <= !wr;
      avs_write_in     <= wr;
      w = 1'b1;
      for (n = 0; n < 50 && w !== 1'b0; n++) begin
         @(posedge clk_in);
         w = avs_waitrequest_out;
         r = avs_readdata_out;
      end
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
      if (w !== 1'b0) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic load(input logic [3:0] r, input logic [4:0] c);
      addr_row_in  <= r;
      addr_col_in  <= c;
      addr_load_in <= 1'b1;
      @(posedge clk_in);
      addr_load_in <= 1'b0;
      @(posedge clk_in);
   endtask
   // every video ram write must match the next expected one
   always @(negedge clk_in) begin
      if (vram_we_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            chk({9'h0, vram_row_out, vram_col_out, vram_attr_out, vram_pattern_out}, {9'h0, exp_q.pop_front()});
         end
      end
   end
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   initial begin
      repeat (90000) @(posedge clk_in);
      n_errors++;
      print_verdict();
   end
   initial begin
      {rst_n_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
      {factory_check_in, addr_load_in, addr_row_in, addr_col_in, cell_attr_in, pattern_code_in} = '0;
      {cell_dots_in, cell_top_in, cell_bot_in, min_bg_area_in, blink_phase_in} = '0;
      avs_byteenable_in = 4'hF;
      osc_running_in = 1'b1;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      bus(1'b0, CTRL_OFS, 32'h0, q);
      chk(q, {16'h0, CTRL_RST});
      bus(1'b0, 4'h8, 32'h0, q);
      chk(q, 32'h0);
      foreach (rows[i]) begin
         bus(1'b1, CTRL_OFS, {16'h0, rows[i].ctrl}, q);
         cell_attr_in    <= rows[i].attr;
         pattern_code_in <= rows[i].code;
         cell_dots_in    <= rows[i].dots;
         {cell_top_in, cell_bot_in, min_bg_area_in, blink_phase_in} <= rows[i].ctl;
         repeat (2) @(posedge clk_in);
         @(negedge clk_in);
         chk({24'h0, rgb_out, pri_out, sec_out, rgb_blank_out, pri_blank_out, sec_blank_out},
             {24'h0, rows[i].exp});
         @(posedge clk_in);
      end
      // only the low byte lane of the control word is written
      avs_byteenable_in <= 4'h1;
      bus(1'b1, CTRL_OFS, 32'h0000_FFFF, q);
      avs_byteenable_in <= 4'hF;
      bus(1'b0, CTRL_OFS, 32'h0, q);
      chk(q, 32'h0000_04FF);
      // continuous input with wrap, end code, then new first byte under low select
      load(4'hB, 5'h16);
      exp_q.push_back({4'hB, 5'h16, 6'h12, 8'h41});
      exp_q.push_back({4'hB, 5'h17, 6'h12, 8'h42});
      exp_q.push_back({4'h0, 5'h00, 6'h12, 8'h43});
      exp_q.push_back({4'h0, 5'h01, 6'h01, 8'hFE});
      foreach (seq[k]) begin
         host.send_byte(seq[k]);
      end
      bus(1'b0, STAT_OFS, 32'h0, q);
      chk({q[13], q[11:8], q[4:0]}, {1'b1, 4'h0, 5'h02});
      host.end_frame();
      bus(1'b0, STAT_OFS, 32'h0, q);
      chk({31'h0, q[13]}, 32'h0);
      // select raised after a first byte; next bytes are one-byte commands
      host.send_byte(8'hC0);
      host.end_frame();
      host.send_byte(8'h41);
      host.send_byte(8'h42);
      host.end_frame();
      // oscillator stopped drops the write and holds the address
      osc_running_in <= 1'b0;
      host.send_byte(8'hC0);
      host.send_byte(8'h41);
      host.end_frame();
      osc_running_in <= 1'b1;
      bus(1'b0, STAT_OFS, 32'h0, q);
      chk({27'h0, q[4:0]}, 32'h2);
      load(4'h3, 5'h17);
      exp_q.push_back({4'h3, 5'h17, 6'h00, 8'h10});
      exp_q.push_back({4'h4, 5'h00, 6'h00, 8'h11});
      host.send_byte(8'hC0);
      host.send_byte(8'h10);
      host.send_byte(8'h11);
      host.end_frame();
      // test command refused with check pin low, taken with it high
      host.send_byte(8'hB1);
      host.send_byte(8'hFF);
      host.end_frame();
      chk({31'h0, test_mode_out}, 32'h0);
      factory_check_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      host.send_byte(8'hB1);
      host.send_byte(8'hFF);
      host.end_frame();
      chk({22'h0, test_mode_out, factory_check_field_out}, {22'h0, 1'b1, 9'h1FF});
      chk(exp_q.size(), 32'h0);
      print_verdict();
   end
endmodule
